// ===== hw/eadl_ctrl.v
`timescale 1ns/1ps
`include "eadl_map.vh"
// External area decoder and bus cycle sequencer
module eadl_ctrl #(
  parameter COL_BITS = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire req_valid,
  input wire [31:0] req_addr,
  input wire req_write,
  input wire [1:0] req_size,
  input wire [31:0] req_wdata,
  output wire req_ready,
  output wire rsp_valid,
  output wire [31:0] rsp_rdata,
  output wire rsp_err,
  output wire periph_sel,
  input wire boot_width_pin_a,
  input wire boot_width_pin_b,
  input wire [2:0] area0_wait_count,
  input wire area0_burst_en,
  input wire area2_width_hi,
  input wire area2_width_lo,
  input wire area2_wait_count_hi,
  input wire area2_wait_count_lo,
  input wire area2_is_sdram,
  input wire area3_width_hi,
  input wire area3_width_lo,
  input wire area3_wait_count_hi,
  input wire area3_wait_count_lo,
  input wire area3_is_sdram,
  input wire area4_width_hi,
  input wire area4_width_lo,
  input wire [2:0] area4_wait_count,
  input wire [3:0] sdram_ctrl_reg,
  input wire ext_wait_n,
  input wire [31:0] data_in,
  output wire [31:0] data_out,
  output wire data_oe_n,
  output wire [25:0] ext_addr,
  output wire area0_select_n,
  output wire area2_select_n,
  output wire area3_select_n,
  output wire area4_select_n,
  output wire rd_n,
  output wire [3:0] byte_write_strobes_n,
  output wire bus_cycle_start_n,
  output wire row_strobe_upper_n,
  output wire row_strobe_lower_n,
  output wire col_strobe_upper_n,
  output wire col_strobe_lower_n,
  output wire rd_wr_n,
  output wire lane_mask_3,
  output wire lane_mask_2,
  output wire lane_mask_1,
  output wire lane_mask_0
);
  // One-hot sequencer states
  localparam ST_IDLE = 10'h001;
  localparam ST_SETUP = 10'h002;
  localparam ST_T1 = 10'h004;
  localparam ST_TW = 10'h008;
  localparam ST_T2 = 10'h010;
  localparam ST_SROW = 10'h020;
  localparam ST_SGAP = 10'h040;
  localparam ST_SLAT = 10'h080;
  localparam ST_FIN = 10'h100;
  localparam ST_SCOL = 10'h200; // SDRAM column command

  reg [9:0] state_ff, nxt_state; // Sequencer state
  reg ready_ff, nxt_ready; // Request port free
  reg rsp_ff, nxt_rsp; // Response pulse
  reg err_ff, nxt_err; // Unmapped area flag
  reg periph_ff, nxt_periph; // Internal area pulse
  reg [31:0] rdata_ff, nxt_rdata; // Assembled read data
  reg [25:0] acc_addr_ff, nxt_acc_addr; // Latched address
  reg acc_write_ff, nxt_acc_write; // Latched direction
  reg [1:0] acc_size_ff, nxt_acc_size; // Latched size
  reg [31:0] acc_wdata_ff, nxt_acc_wdata; // Latched write data
  reg [1:0] acc_width_ff, nxt_acc_width; // Device width
  reg [3:0] acc_area_ff, nxt_acc_area; // One-hot area 0,2,3,4
  reg [3:0] acc_wait_ff, nxt_acc_wait; // Software waits
  reg acc_xwait_ff, nxt_acc_xwait; // Wait pin honoured
  reg acc_burst_ff, nxt_acc_burst; // Burst beats
  reg acc_sdram_ff, nxt_acc_sdram; // SDRAM sequence
  reg [1:0] beat_ff, nxt_beat; // Current beat
  reg [3:0] cnt_ff, nxt_cnt; // Wait and delay counter
  reg cap1_ff, nxt_cap1; // Capture pipe stage 1
  reg cap2_ff, nxt_cap2; // Capture pipe stage 2
  reg [1:0] capb1_ff, nxt_capb1; // Beat of stage 1
  reg [1:0] capb2_ff, nxt_capb2; // Beat of stage 2
  reg [3:0] sel_ff, nxt_sel; // Chip selects, low active
  reg rd_ff, nxt_rd; // Read strobe, low active
  reg [3:0] we_ff, nxt_we; // Byte write strobes, low active
  reg bstart_ff, nxt_bstart; // Bus start, low active
  reg [25:0] addr_ff, nxt_addr; // Address pins
  reg [31:0] dout_ff, nxt_dout; // Data pins out
  reg oe_ff, nxt_oe; // Data enable, low drives
  reg ras_ff, nxt_ras; // Row strobe, low active
  reg cas_ff, nxt_cas; // Column strobe, low active
  reg rdwr_ff, nxt_rdwr; // SDRAM write when low
  reg [3:0] mask_ff, nxt_mask; // Lane masks, high masks
  // Pin synchronisers
  reg boot_a_s1_ff, boot_a_s2_ff;
  reg boot_b_s1_ff, boot_b_s2_ff;
  reg wait_s1_ff, wait_s2_ff;
  reg [31:0] din_s1_ff, din_s2_ff;

  reg [2:0] area_code; // Decoded area code
  reg [3:0] w0_dec, w4_dec; // Decoded three-bit waits
  wire [1:0] beat_sel; // Beat for the pins being set up
  wire [2:0] beat_count;
  wire [1:0] st_addr_lo;
  wire [3:0] st_lanes;
  wire [31:0] st_data;
  wire [31:0] rd_part;
  wire [3:0] beat_wait; // Waits for the next beat
  wire last_beat; // Current beat is final

  // Three-bit wait field decode
  function [3:0] wait3;
    input [2:0] f;
    begin
      case (f)
        3'h0: wait3 = `EADL_WAIT3_0;
        3'h1: wait3 = `EADL_WAIT3_1;
        3'h2: wait3 = `EADL_WAIT3_2;
        3'h3: wait3 = `EADL_WAIT3_3;
        3'h4: wait3 = `EADL_WAIT3_4;
        3'h5: wait3 = `EADL_WAIT3_5;
        3'h6: wait3 = `EADL_WAIT3_6;
        default: wait3 = `EADL_WAIT3_7;
      endcase
    end
  endfunction

  // Steering for pins set up now and for data coming back
  assign beat_sel = state_ff[4] ? beat_ff + 2'h1 : beat_ff;
  eadl_lane_steer u_steer (
    .dev_width(acc_width_ff),
    .acc_size(acc_size_ff),
    .addr_lo(acc_addr_ff[1:0]),
    .wr_beat(beat_sel),
    .wdata(acc_wdata_ff),
    .rd_beat(capb2_ff),
    .din(din_s2_ff),
    .beat_count(beat_count),
    .wr_addr_lo(st_addr_lo),
    .wr_lanes(st_lanes),
    .wr_lane_data(st_data),
    .rd_part(rd_part)
  );

  // Burst beats after the first cap waits, pitch 2..10 clocks
  assign beat_wait = (acc_burst_ff && beat_sel != 2'h0 &&
                      acc_wait_ff > `EADL_BURST_WAIT_MAX) ?
                     `EADL_BURST_WAIT_MAX : acc_wait_ff;
  assign last_beat = ({1'b0, beat_ff} + 3'h1) >= beat_count;

  // Next-state and pin logic
  always @* begin
    nxt_state = state_ff;
    nxt_ready = ready_ff;
    nxt_rsp = 1'b0;
    nxt_err = err_ff;
    nxt_periph = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_acc_addr = acc_addr_ff;
    nxt_acc_write = acc_write_ff;
    nxt_acc_size = acc_size_ff;
    nxt_acc_wdata = acc_wdata_ff;
    nxt_acc_width = acc_width_ff;
    nxt_acc_area = acc_area_ff;
    nxt_acc_wait = acc_wait_ff;
    nxt_acc_xwait = acc_xwait_ff;
    nxt_acc_burst = acc_burst_ff;
    nxt_acc_sdram = acc_sdram_ff;
    nxt_beat = beat_ff;
    nxt_cnt = cnt_ff;
    nxt_sel = sel_ff;
    nxt_rd = rd_ff;
    nxt_we = we_ff;
    nxt_bstart = bstart_ff;
    nxt_addr = addr_ff;
    nxt_dout = dout_ff;
    nxt_oe = oe_ff;
    nxt_ras = ras_ff;
    nxt_cas = cas_ff;
    nxt_rdwr = rdwr_ff;
    nxt_mask = mask_ff;
    // Capture pipe matches the data synchroniser depth
    nxt_cap1 = 1'b0;
    nxt_capb1 = beat_ff;
    nxt_cap2 = cap1_ff;
    nxt_capb2 = capb1_ff;
    if (cap2_ff) begin
      nxt_rdata = rdata_ff | rd_part;
    end
    // Area code from bits 28-26, bits 31-29 ignored
    area_code = req_addr[`EADL_AREA_MSB:`EADL_AREA_LSB];
    w0_dec = wait3(area0_wait_count);
    w4_dec = wait3(area4_wait_count);
    case (state_ff)
      ST_IDLE: begin
        if (req_valid && ready_ff) begin
          nxt_acc_addr = req_addr[25:0];
          nxt_acc_write = req_write;
          nxt_acc_size = req_size;
          nxt_acc_wdata = req_wdata;
          nxt_rdata = `EADL_RST_DATA;
          nxt_beat = 2'h0;
          nxt_err = 1'b0;
          nxt_acc_burst = 1'b0;
          nxt_acc_sdram = 1'b0;
          nxt_acc_xwait = 1'b0;
          nxt_ready = 1'b0;
          nxt_state = ST_SETUP;
          case (area_code)
            `EADL_AREA0: begin
              nxt_acc_area = 4'h1;
              nxt_acc_width = {boot_b_s2_ff, boot_a_s2_ff};
              nxt_acc_wait = w0_dec;
              nxt_acc_burst = area0_burst_en;
            end
            `EADL_AREA1: begin
              // Internal registers only, no external cycle
              nxt_periph = 1'b1;
              nxt_rsp = 1'b1;
              nxt_ready = 1'b1;
              nxt_state = ST_IDLE;
            end
            `EADL_AREA2: begin
              nxt_acc_area = 4'h2;
              nxt_acc_sdram = area2_is_sdram;
              nxt_acc_width = area2_is_sdram ? `EADL_SZ_LONG :
                {area2_width_hi, area2_width_lo};
              nxt_acc_wait = {2'b00, area2_wait_count_hi,
                              area2_wait_count_lo};
              // Wait pin ignored with SDRAM attached
              nxt_acc_xwait = !area2_is_sdram &&
                (area2_wait_count_hi || area2_wait_count_lo);
            end
            `EADL_AREA3: begin
              nxt_acc_area = 4'h4;
              nxt_acc_sdram = area3_is_sdram;
              nxt_acc_width = area3_is_sdram ? `EADL_SZ_LONG :
                {area3_width_hi, area3_width_lo};
              nxt_acc_wait = {2'b00, area3_wait_count_hi,
                              area3_wait_count_lo};
              nxt_acc_xwait = !area3_is_sdram &&
                (area3_wait_count_hi || area3_wait_count_lo);
            end
            `EADL_AREA4: begin
              nxt_acc_area = 4'h8;
              nxt_acc_width = {area4_width_hi, area4_width_lo};
              nxt_acc_wait = w4_dec;
              nxt_acc_xwait = (w4_dec != 4'h0);
            end
            default: begin
              // Areas not handled here answer with an error
              nxt_err = 1'b1;
              nxt_rsp = 1'b1;
              nxt_ready = 1'b1;
              nxt_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_SETUP: begin
        // Only the decoded area's select goes low
        nxt_sel = ~acc_area_ff;
        nxt_bstart = 1'b0;
        if (acc_sdram_ff) begin
          // Row phase with the upper address bits
          nxt_ras = 1'b0;
          nxt_addr = acc_addr_ff >> (COL_BITS + 2);
          nxt_state = ST_SROW;
        end else begin
          nxt_rd = acc_write_ff;
          nxt_we = acc_write_ff ? ~st_lanes : `EADL_RST_LANES;
          nxt_addr = {acc_addr_ff[25:2], st_addr_lo};
          nxt_dout = st_data;
          nxt_oe = ~acc_write_ff;
          nxt_cnt = beat_wait;
          nxt_state = ST_T1;
        end
      end
      ST_T1: begin
        // Start pulse lasts one clock
        nxt_bstart = 1'b1;
        nxt_state = (cnt_ff == 4'h0) ? ST_T2 : ST_TW;
      end
      ST_TW: begin
        // Wait pin sampled on the last software wait
        if (!(cnt_ff == 4'h1 && acc_xwait_ff && !wait_s2_ff)) begin
          nxt_cnt = cnt_ff - 4'h1;
          if (cnt_ff == 4'h1) begin
            nxt_state = ST_T2;
          end
        end
      end
      ST_T2: begin
        // Read data taken at the end of T2
        nxt_cap1 = ~acc_write_ff;
        if (last_beat) begin
          nxt_state = ST_FIN;
        end else begin
          // Next beat of a split access
          nxt_beat = beat_ff + 2'h1;
          nxt_bstart = acc_burst_ff;
          nxt_we = acc_write_ff ? ~st_lanes : `EADL_RST_LANES;
          nxt_addr = {acc_addr_ff[25:2], st_addr_lo};
          nxt_dout = st_data;
          nxt_cnt = beat_wait;
          nxt_state = ST_T1;
        end
      end
      ST_SROW: begin
        nxt_ras = 1'b1;
        nxt_bstart = 1'b1;
        nxt_cnt = {2'b00,
          sdram_ctrl_reg[`EADL_SDR_RCD_MSB:`EADL_SDR_RCD_LSB]};
        nxt_state = ST_SGAP;
      end
      ST_SGAP: begin
        if (cnt_ff == 4'h0) begin
          // Column phase with masks and direction
          nxt_cas = 1'b0;
          nxt_rdwr = ~acc_write_ff;
          nxt_addr = (acc_addr_ff >> 2) &
                     ((26'h000_0001 << COL_BITS) - 26'h000_0001);
          nxt_mask = acc_write_ff ? ~st_lanes : 4'h0;
          nxt_dout = st_data;
          nxt_oe = ~acc_write_ff;
          nxt_state = ST_SCOL;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_SCOL: begin
        nxt_cas = 1'b1;
        nxt_rdwr = 1'b1;
        nxt_cnt = {2'b00,
          sdram_ctrl_reg[`EADL_SDR_CL_MSB:`EADL_SDR_CL_LSB]};
        nxt_state = acc_write_ff ? ST_FIN : ST_SLAT;
      end
      ST_SLAT: begin
        // CAS latency before the read word is sampled
        if (cnt_ff == 4'h0) begin
          nxt_cap1 = 1'b1;
          nxt_state = ST_FIN;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_FIN: begin
        // Answer once every captured beat has merged
        if (!cap1_ff && !cap2_ff) begin
          nxt_rsp = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
    // Pins released as the cycle ends
    if (nxt_state == ST_FIN && state_ff != ST_FIN) begin
      nxt_sel = `EADL_RST_LANES;
      nxt_rd = 1'b1;
      nxt_we = `EADL_RST_LANES;
      nxt_oe = 1'b1;
      nxt_bstart = 1'b1;
      nxt_mask = `EADL_RST_LANES;
    end
  end

  // Registers and pin synchronisers
  always @(posedge clk) begin
    boot_a_s1_ff <= boot_width_pin_a;
    boot_a_s2_ff <= boot_a_s1_ff;
    boot_b_s1_ff <= boot_width_pin_b;
    boot_b_s2_ff <= boot_b_s1_ff;
    wait_s1_ff <= ext_wait_n;
    wait_s2_ff <= wait_s1_ff;
    din_s1_ff <= data_in;
    din_s2_ff <= din_s1_ff;
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      ready_ff <= 1'b1;
      rsp_ff <= 1'b0;
      err_ff <= 1'b0;
      periph_ff <= 1'b0;
      rdata_ff <= `EADL_RST_DATA;
      acc_addr_ff <= `EADL_RST_ADDR;
      acc_write_ff <= 1'b0;
      acc_size_ff <= `EADL_SZ_LONG;
      acc_wdata_ff <= `EADL_RST_DATA;
      acc_width_ff <= `EADL_SZ_LONG;
      acc_area_ff <= 4'h0;
      acc_wait_ff <= 4'h0;
      acc_xwait_ff <= 1'b0;
      acc_burst_ff <= 1'b0;
      acc_sdram_ff <= 1'b0;
      beat_ff <= 2'h0;
      cnt_ff <= 4'h0;
      cap1_ff <= 1'b0;
      cap2_ff <= 1'b0;
      capb1_ff <= 2'h0;
      capb2_ff <= 2'h0;
      sel_ff <= `EADL_RST_LANES;
      rd_ff <= 1'b1;
      we_ff <= `EADL_RST_LANES;
      bstart_ff <= 1'b1;
      addr_ff <= `EADL_RST_ADDR;
      dout_ff <= `EADL_RST_DATA;
      oe_ff <= 1'b1;
      ras_ff <= 1'b1;
      cas_ff <= 1'b1;
      rdwr_ff <= 1'b1;
      mask_ff <= `EADL_RST_LANES;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      rsp_ff <= nxt_rsp;
      err_ff <= nxt_err;
      periph_ff <= nxt_periph;
      rdata_ff <= nxt_rdata;
      acc_addr_ff <= nxt_acc_addr;
      acc_write_ff <= nxt_acc_write;
      acc_size_ff <= nxt_acc_size;
      acc_wdata_ff <= nxt_acc_wdata;
      acc_width_ff <= nxt_acc_width;
      acc_area_ff <= nxt_acc_area;
      acc_wait_ff <= nxt_acc_wait;
      acc_xwait_ff <= nxt_acc_xwait;
      acc_burst_ff <= nxt_acc_burst;
      acc_sdram_ff <= nxt_acc_sdram;
      beat_ff <= nxt_beat;
      cnt_ff <= nxt_cnt;
      cap1_ff <= nxt_cap1;
      cap2_ff <= nxt_cap2;
      capb1_ff <= nxt_capb1;
      capb2_ff <= nxt_capb2;
      sel_ff <= nxt_sel;
      rd_ff <= nxt_rd;
      we_ff <= nxt_we;
      bstart_ff <= nxt_bstart;
      addr_ff <= nxt_addr;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
      ras_ff <= nxt_ras;
      cas_ff <= nxt_cas;
      rdwr_ff <= nxt_rdwr;
      mask_ff <= nxt_mask;
    end
  end

  // Outputs straight from registers
  assign req_ready = ready_ff;
  assign rsp_valid = rsp_ff;
  assign rsp_rdata = rdata_ff;
  assign rsp_err = err_ff;
  assign periph_sel = periph_ff;
  assign data_out = dout_ff;
  assign data_oe_n = oe_ff;
  assign ext_addr = addr_ff;
  assign area0_select_n = sel_ff[0];
  assign area2_select_n = sel_ff[1];
  assign area3_select_n = sel_ff[2];
  assign area4_select_n = sel_ff[3];
  assign rd_n = rd_ff;
  assign byte_write_strobes_n = we_ff;
  assign bus_cycle_start_n = bstart_ff;
  assign row_strobe_upper_n = ras_ff;
  assign row_strobe_lower_n = ras_ff;
  assign col_strobe_upper_n = cas_ff;
  assign col_strobe_lower_n = cas_ff;
  assign rd_wr_n = rdwr_ff;
  assign lane_mask_3 = mask_ff[3];
  assign lane_mask_2 = mask_ff[2];
  assign lane_mask_1 = mask_ff[1];
  assign lane_mask_0 = mask_ff[0];
endmodule // eadl_ctrl

// ===== hw/eadl_lane_steer.v
`timescale 1ns/1ps
`include "eadl_map.vh"
// Little-endian lane steering for 8, 16 and 32-bit devices
module eadl_lane_steer (
  input wire [1:0] dev_width,
  input wire [1:0] acc_size,
  input wire [1:0] addr_lo,
  input wire [1:0] wr_beat,
  input wire [31:0] wdata,
  input wire [1:0] rd_beat,
  input wire [31:0] din,
  output reg [2:0] beat_count,
  output wire [1:0] wr_addr_lo,
  output wire [3:0] wr_lanes,
  output wire [31:0] wr_lane_data,
  output wire [31:0] rd_part
);
  reg [2:0] abytes; // Bytes in the access
  reg [2:0] step; // Bytes per beat
  reg [1:0] dmask; // Lane offset mask of the device
  reg [3:0] bmask; // Strobe pattern of one beat
  reg [31:0] vmask; // Data mask of one beat
  wire [2:0] w_ofs; // Byte offset of write beat in access
  wire [2:0] r_ofs; // Byte offset of read beat in access
  wire [1:0] w_lane; // Lane where write beat lands
  wire [1:0] r_lane; // Lane where read beat arrives

  // Sizes, beat count and per-beat masks
  always @* begin
    case (acc_size)
      `EADL_SZ_BYTE: abytes = 3'h1;
      `EADL_SZ_WORD: abytes = 3'h2;
      default: abytes = 3'h4;
    endcase
    case (dev_width)
      `EADL_SZ_BYTE: dmask = 2'h0;
      `EADL_SZ_WORD: dmask = 2'h1;
      default: dmask = 2'h3;
    endcase
    // Beat is the smaller of access and device width
    step = (abytes > ({1'b0, dmask} + 3'h1)) ?
           ({1'b0, dmask} + 3'h1) : abytes;
    // Low lanes of one beat strobed and kept
    bmask = (4'h1 << step) - 4'h1;
    vmask = {{8{bmask[3]}}, {8{bmask[2]}}, {8{bmask[1]}}, {8{bmask[0]}}};
    // Longword on 8-bit device four beats, on 16-bit two
    beat_count = abytes / step;
  end

  // Least significant part goes first
  assign w_ofs = {1'b0, wr_beat} * step;
  assign r_ofs = {1'b0, rd_beat} * step;
  assign wr_addr_lo = addr_lo + w_ofs[1:0];
  // Even bytes low lane, odd upper lane; 8-bit all on lane 0
  assign w_lane = wr_addr_lo & dmask;
  assign r_lane = (addr_lo + r_ofs[1:0]) & dmask;
  // Only the written bytes are strobed
  assign wr_lanes = bmask << w_lane;
  assign wr_lane_data = ((wdata >> {w_ofs, 3'b000}) & vmask)
                        << {w_lane, 3'b000};
  // Read beat realigned into the access word
  assign rd_part = ((din >> {r_lane, 3'b000}) & vmask) << {r_ofs, 3'b000};
endmodule // eadl_lane_steer

// ===== hw/eadl_map.vh
`ifndef EADL_MAP_VH
`define EADL_MAP_VH
// Functional notes
// - Area from address bits 28-26 only
// - Code 000 selects area 0 static memory
// - Area 0 width from two boot pins
// - Area 0 drives its select, read, write strobes
// - Area 0 three-bit wait field, 0-10 waits
// - Area 0 burst pitch 2 to 10 clocks
// - Area 1 internal only, never external
// - Area 2 width from two-bit size field
// - Area 2 select, strobes, 0-3 waits
// - Area 2 wait pin only for ordinary memory
// - SDRAM gets row, column, mask, muxed address
// - Area 3 select always, two-bit width field
// - Area 3 ordinary strobes, 0-3 waits
// - Area 4 ordinary only, select, width field
// - Area 4 0-10 waits plus wait pin
// - 16-bit device: even low lane, long split
// - 8-bit device: lowest lane, LSB first
// - No-wait access two clocks, start pulse
// - Reads full device width, writes strobe bytes

// Area code field inside the physical address
`define EADL_AREA_MSB 28
`define EADL_AREA_LSB 26
`define EADL_AREA0 3'h0
`define EADL_AREA1 3'h1
`define EADL_AREA2 3'h2
`define EADL_AREA3 3'h3
`define EADL_AREA4 3'h4

// Access size and device width encodings (00 is read as longword)
`define EADL_SZ_BYTE 2'h1
`define EADL_SZ_WORD 2'h2
`define EADL_SZ_LONG 2'h3

// Three-bit wait field decoded to wait cycles
`define EADL_WAIT3_0 4'h0
`define EADL_WAIT3_1 4'h1
`define EADL_WAIT3_2 4'h2
`define EADL_WAIT3_3 4'h3
`define EADL_WAIT3_4 4'h4
`define EADL_WAIT3_5 4'h6
`define EADL_WAIT3_6 4'h8
`define EADL_WAIT3_7 4'hA

// Burst beats cap their waits so the pitch stays within 10 clocks
`define EADL_BURST_WAIT_MAX 4'h8

// SDRAM control field positions
`define EADL_SDR_RCD_MSB 1
`define EADL_SDR_RCD_LSB 0
`define EADL_SDR_CL_MSB 3
`define EADL_SDR_CL_LSB 2

// Reset values
`define EADL_RST_DATA 32'h0000_0000
`define EADL_RST_ADDR 26'h000_0000
`define EADL_RST_LANES 4'hF
`endif

// ===== testbench/eadl_assertions.sv
`timescale 1ns/1ps
// Port-level checks on area decode and strobe timing
module eadl_assertions (
  input wire clk,
  input wire sys_rst,
  input wire req_valid,
  input wire [31:0] req_addr,
  input wire req_ready,
  input wire rsp_valid,
  input wire rsp_err,
  input wire periph_sel,
  input wire area0_select_n,
  input wire area2_select_n,
  input wire area3_select_n,
  input wire area4_select_n,
  input wire rd_n,
  input wire [3:0] byte_write_strobes_n,
  input wire bus_cycle_start_n,
  input wire row_strobe_lower_n
);
  // Selects as active-high, area 0 in bit 0
  wire [3:0] sel = ~{area4_select_n, area3_select_n, area2_select_n,
    area0_select_n};
  wire take = req_valid && req_ready;
  wire [2:0] ac = req_addr[28:26];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_one_sel; $onehot0(sel); endproperty
  a_one_sel: assert property (p_one_sel)
    else $error("two selects low");
  property p_start; !bus_cycle_start_n |-> sel != 4'h0 ##1 bus_cycle_start_n;
  endproperty
  a_start: assert property (p_start)
    else $error("start pulse wrong");
  property p_rd; !rd_n |-> &byte_write_strobes_n; endproperty
  a_rd: assert property (p_rd)
    else $error("write strobe during read");
  property p_periph;
    take && ac == 3'h1 |-> ##[1:2] (periph_sel && sel == 4'h0);
  endproperty
  a_periph: assert property (p_periph)
    else $error("area 1 reached pins");
  property p_err;
    take && ac > 3'h4 |-> ##[1:2] (rsp_valid && rsp_err && sel == 4'h0);
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped area not refused");
  property p_a0;
    take && ac == 3'h0 |-> ##[1:3] (sel == 4'h1 && !bus_cycle_start_n);
  endproperty
  a_a0: assert property (p_a0)
    else $error("area 0 select missing");
  property p_a4;
    take && ac == 3'h4 |-> ##[1:3] (sel == 4'h8 && !bus_cycle_start_n);
  endproperty
  a_a4: assert property (p_a4)
    else $error("area 4 select missing");
  property p_sdr; !row_strobe_lower_n |-> rd_n && (sel[1] || sel[2]);
  endproperty
  a_sdr: assert property (p_sdr)
    else $error("row strobe outside sdram area");
  property p_rsp; rsp_valid |-> req_ready ##1 !rsp_valid; endproperty
  a_rsp: assert property (p_rsp)
    else $error("response pulse wrong");
endmodule // eadl_assertions
bind eadl_ctrl eadl_assertions u_eadl_assertions (.*);

// ===== testbench/eadl_mem_model.sv
`timescale 1ns/1ps
// Byte-addressed static memory of 8, 16 or 32 bits width
module eadl_mem_model (
  input wire clk,
  input wire sel_n,
  input wire rd_n,
  input wire [3:0] we_n,
  input wire [25:0] addr,
  input wire [31:0] wdata,
  input wire [1:0] width,
  input wire stall,
  output reg [31:0] rdata,
  output wire wait_n
);
  reg [7:0] mem [0:255];
  reg [31:0] last_ff;
  integer i;
  // Byte address of a lane for the device width
  function [7:0] ba(input [7:0] a, input [1:0] w, input [1:0] l);
    ba = w == 2'h1 ? a :
         w == 2'h2 ? {a[7:1], l[0]} : {a[7:2], l};
  endfunction
  assign wait_n = !stall;
  // Only strobed lanes are written
  always @(posedge clk) begin
    for (i = 0; i < 4; i = i + 1)
      if (!sel_n && !we_n[i])
        mem[ba(addr[7:0], width, i)] <= wdata[8*i +: 8];
    last_ff <= rdata;
  end
  // Released bus shows the inverse of its last value
  always @* begin
    rdata = ~last_ff;
    if (!sel_n && !rd_n) begin
      rdata = {mem[ba(addr[7:0], width, 3)], mem[ba(addr[7:0], width, 2)],
        mem[ba(addr[7:0], width, 1)], mem[ba(addr[7:0], width, 0)]};
    end
  end
endmodule // eadl_mem_model

// ===== testbench/test_eadl_ctrl.sv
`timescale 1ns/1ps
module test_eadl_ctrl;
  reg clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, stall = 0;
  reg [31:0] req_addr = 0, req_wdata = 0;
  reg [1:0] req_size = 0, boot = 2'h3, a2sz = 0, a2w = 0, a3sz = 0, a3w = 0;
  reg [1:0] a4sz = 0, mw = 2'h3;
  reg [2:0] a0w = 0, a4w = 0;
  reg sdr3 = 0, saw_row = 0;
  integer lat, l0, mismatches = 0, checked = 0, cyc = 0, k;
  wire [31:0] din, rsp_rdata, dout;
  wire [25:0] ext_addr;
  wire [3:0] we_n;
  wire req_ready, rsp_valid, rsp_err, s0, s2, s3, s4, rd_n, wt_n, row_n;
  always #10 clk = ~clk;
  eadl_ctrl u_eadl_ctrl (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
    .req_size(req_size), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
    .periph_sel(), .boot_width_pin_a(boot[0]), .boot_width_pin_b(boot[1]),
    .area0_wait_count(a0w), .area0_burst_en(1'b0),
    .area2_width_hi(a2sz[1]), .area2_width_lo(a2sz[0]),
    .area2_wait_count_hi(a2w[1]), .area2_wait_count_lo(a2w[0]),
    .area2_is_sdram(1'b0), .area3_width_hi(a3sz[1]),
    .area3_width_lo(a3sz[0]), .area3_wait_count_hi(a3w[1]),
    .area3_wait_count_lo(a3w[0]), .area3_is_sdram(sdr3),
    .area4_width_hi(a4sz[1]), .area4_width_lo(a4sz[0]),
    .area4_wait_count(a4w), .sdram_ctrl_reg(4'h0), .ext_wait_n(wt_n),
    .data_in(din), .data_out(dout), .data_oe_n(), .ext_addr(ext_addr),
    .area0_select_n(s0), .area2_select_n(s2), .area3_select_n(s3),
    .area4_select_n(s4), .rd_n(rd_n), .byte_write_strobes_n(we_n),
    .bus_cycle_start_n(), .row_strobe_upper_n(), .row_strobe_lower_n(row_n),
    .col_strobe_upper_n(), .col_strobe_lower_n(), .rd_wr_n(),
    .lane_mask_3(), .lane_mask_2(), .lane_mask_1(), .lane_mask_0());
  eadl_mem_model u_eadl_mem_model (.clk(clk), .sel_n(s0 & s2 & s3 & s4),
    .rd_n(rd_n), .we_n(we_n), .addr(ext_addr), .wdata(dout), .width(mw),
    .stall(stall), .rdata(din), .wait_n(wt_n));
  // Cycle ceiling and row strobe watch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!row_n && !s3) saw_row <= 1'b1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  // One request, latency counted in cycles to the response
  task acc(input [31:0] a, input w, input [1:0] s, input [31:0] d);
    begin
      @(posedge clk);
      req_addr <= a;
      req_write <= w;
      req_size <= s;
      req_wdata <= d;
      req_valid <= 1'b1;
      @(negedge clk);
      while (!req_ready) @(negedge clk);
      @(posedge clk);
      req_valid <= 1'b0;
      lat = 0;
      @(negedge clk);
      while (rsp_valid !== 1'b1 && lat < 400) begin
        @(negedge clk);
        lat = lat + 1;
      end
      if (lat >= 400) chk(0, 1);
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    // Area 0, 32-bit boot width: waits and shadow read
    acc(32'h0000_0010, 1, 2'h3, 32'hA1B2_C3D4);
    l0 = lat;
    a0w <= 3'h5;
    acc(32'h0000_0010, 1, 2'h3, 32'hA1B2_C3D4);
    chk(lat - l0, 6);
    acc(32'h2000_0010, 0, 2'h3, 0);
    chk(rsp_rdata, 32'hA1B2_C3D4);
    // Area 2, 16-bit: two beats per long, odd byte on upper lane
    a2sz <= 2'h2;
    mw <= 2'h2;
    acc(32'h0800_0020, 1, 2'h3, 32'h1122_3344);
    l0 = lat;
    a2w <= 2'h3;
    acc(32'h0800_0020, 1, 2'h3, 32'h1122_3344);
    chk(lat - l0, 6);
    acc(32'h0800_0021, 1, 2'h1, 32'h0000_0055);
    acc(32'h0800_0020, 0, 2'h3, 0);
    chk(rsp_rdata, 32'h1122_5544);
    // Area 3 and 4, 8-bit: byte lanes in ascending order
    a3sz <= 2'h1;
    a4sz <= 2'h1;
    mw <= 2'h1;
    acc(32'h0C00_0030, 1, 2'h2, 32'h0000_BEEF);
    acc(32'h0C00_0031, 0, 2'h1, 0);
    chk(rsp_rdata, 32'h0000_00BE);
    acc(32'h1000_0040, 1, 2'h3, 32'h0102_0304);
    for (k = 0; k < 4; k = k + 1) begin
      acc(32'h1000_0040 + k, 0, 2'h1, 0);
      chk(rsp_rdata, 4 - k);
    end
    acc(32'h1000_0040, 1, 2'h1, 32'h0000_0004);
    l0 = lat;
    a4w <= 3'h7;
    acc(32'h1000_0040, 1, 2'h1, 32'h0000_0004);
    chk(lat - l0, 10);
    l0 = lat;
    stall <= 1'b1;
    fork
      acc(32'h1000_0040, 1, 2'h1, 32'h0000_0004);
      begin
        repeat (30) @(posedge clk);
        stall <= 1'b0;
      end
    join
    chk(lat > l0 + 15, 1);
    // Area 1, unmapped areas and SDRAM strobes
    acc(32'h0400_0000, 0, 2'h3, 0);
    chk(rsp_err, 0);
    acc(32'hFC00_0000, 0, 2'h3, 0);
    chk(rsp_err, 1);
    sdr3 <= 1'b1;
    acc(32'h0C00_0100, 1, 2'h3, 32'h1234_5678);
    chk(saw_row, 1);
    results;
  end
endmodule // test_eadl_ctrl
